// ==== rtl/ddrci_bank.v ====
// open-row tracker for one bank
module ddrci_bank (
    input  wire clock,
    input  wire rst_b,
    input  wire open_req,
    input  wire close_req,
    output reg  open_q
);

    reg open_d;

    always @* begin
        open_d = open_q;
        if (close_req) begin
            open_d = 1'b0;
        end else if (open_req) begin
            open_d = 1'b1;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            open_q <= 1'b0;
        end else begin
            open_q <= open_d;
        end
    end

endmodule // ddrci_bank

// ==== rtl/ddrci_consts.vh ====
// constants for the ddr2 command and control input stage
`ifndef DDRCI_CONSTS_VH
`define DDRCI_CONSTS_VH

// command code {chip select, row strobe, column strobe, write enable}, all active low
`define DDRCI_CMD_MODE      4'h0
`define DDRCI_CMD_REFRESH   4'h1
`define DDRCI_CMD_PRECHARGE 4'h2
`define DDRCI_CMD_ACTIVE    4'h3
`define DDRCI_CMD_WRITE     4'h4
`define DDRCI_CMD_READ      4'h5
`define DDRCI_CMD_NOP       4'h7

// address bit that doubles as auto precharge and precharge-all select
`define DDRCI_PRE_ALL_BIT   10

// extended mode register 1 fields
`define DDRCI_EMR1_INDEX    2'h1
`define DDRCI_RTT0_BIT      2
`define DDRCI_RTT1_BIT      6
`define DDRCI_STROBE_BIT    11

// reset values
`define DDRCI_MODE_RESET    14'h0000
`define DDRCI_BEATS_RESET   4'h0

// power states, one-hot
`define DDRCI_ST_RUN        4'h1
`define DDRCI_ST_PRE_PD     4'h2
`define DDRCI_ST_ACT_PD     4'h4
`define DDRCI_ST_SELF_REF   4'h8

`endif

// ==== rtl/ddrci_sync.v ====
// two flip-flop synchroniser for a group of pin inputs
module ddrci_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] sync_q
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

endmodule // ddrci_sync

// ==== rtl/ddrci_top.v ====
// ddr2 command, control and write-mask input stage
`include "ddrci_consts.vh"

//
// Contract
// - clock gate high enables clocks, input buffers, drivers; low disables them.
// - gate low: precharge power-down or self refresh if idle, else active power-down.
// - gate sampled on the clock for power-down entry, exit, self-refresh entry.
// - self-refresh exit seen from the gate without a running clock.
// - power-down keeps only clock, termination enable and gate buffers on.
// - self refresh keeps only the gate buffer on.
// - commands ignored on edges where chip select is high.
// - command decoded from chip select and the three strobes.
// - termination enable high terminates data, strobes and masks.
// - termination enable ignored when extended mode disables termination.
// - beats with mask high are not stored.
// - mask sampled on both strobe edges like data.
// - x8: extended mode setting makes mask pin a read strobe.
// - bank select picks the bank for active, read, write, single precharge.
// - bank select picks which mode register a mode set writes.
// - row address on active; column and auto precharge on read and write.
// - precharge: bit ten low closes one bank, high closes all.
// - single-bank precharge uses bank select for the bank.
// - mode set loads register contents from the address inputs.
// - inputs sampled on the rising edge of the clock.
// - x16: lower strobe times lanes 0-7, upper strobe lanes 8-15.
module ddrci_top #(
    parameter ORG       = 16,
    parameter BURST_LEN = 4
) (
    input  wire        clock,
    input  wire        rst_b,
    input  wire        clock_gate_in,
    input  wire        chip_select_b,
    input  wire        row_strobe_b,
    input  wire        col_strobe_b,
    input  wire        write_enable_b,
    input  wire        termination_enable,
    input  wire [2:0]  bank_select,
    input  wire [13:0] address_bus,
    input  wire        lower_data_strobe,
    input  wire        upper_data_strobe,
    input  wire [15:0] data_in,
    input  wire        lower_byte_mask,
    input  wire        upper_byte_mask,
    output reg         clocks_on_q,
    output reg         drivers_en_q,
    output reg         cmd_buf_en_q,
    output reg         clk_buf_en_q,
    output reg  [3:0]  power_state_q,
    output reg         cmd_valid_q,
    output reg  [3:0]  cmd_code_q,
    output reg  [2:0]  cmd_bank_q,
    output reg  [13:0] row_addr_q,
    output reg  [13:0] col_addr_q,
    output reg         auto_precharge_flag_q,
    output reg         precharge_all_select_q,
    output reg         mode_set_cmd_q,
    output reg         extended_mode_set_q,
    output reg  [2:0]  mode_index_q,
    output reg  [13:0] mode_opcode_q,
    output wire [7:0]  bank_open_q,
    output reg         term_dq_q,
    output reg         term_strobe_q,
    output reg         term_mask_q,
    output reg         read_strobe_oe_q,
    output reg         wr_beat_q,
    output reg  [15:0] wr_data_q,
    output reg  [1:0]  wr_lane_store_q
);

    localparam ST_RUN      = `DDRCI_ST_RUN;
    localparam ST_PRE_PD   = `DDRCI_ST_PRE_PD;
    localparam ST_ACT_PD   = `DDRCI_ST_ACT_PD;
    localparam ST_SELF_REF = `DDRCI_ST_SELF_REF;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire [22:0] cmd_s;
    wire [19:0] dat_s;
    wire        wake_s;
    reg         wake_q;

    ddrci_sync #(.WIDTH(23)) u_cmd_sync (
        .clock  (clock),
        .rst_b  (rst_b),
        // select travels inverted: cleared flops must read as deselected
        .pin_in ({clock_gate_in, ~chip_select_b, row_strobe_b, col_strobe_b,
                  write_enable_b, termination_enable, bank_select, address_bus}),
        .sync_q (cmd_s)
    );

    ddrci_sync #(.WIDTH(20)) u_dat_sync (
        .clock  (clock),
        .rst_b  (rst_b),
        .pin_in ({lower_data_strobe, upper_data_strobe, lower_byte_mask,
                  upper_byte_mask, data_in}),
        .sync_q (dat_s)
    );

    ddrci_sync #(.WIDTH(1)) u_wake_sync (
        .clock  (clock),
        .rst_b  (rst_b),
        .pin_in (wake_q),
        .sync_q (wake_s)
    );

    wire        gate_s   = cmd_s[22];
    wire [3:0]  code_s   = {~cmd_s[21], cmd_s[20:18]};
    wire        term_s   = cmd_s[17];
    wire [2:0]  bank_s   = cmd_s[16:14];
    wire [13:0] addr_s   = cmd_s[13:0];
    wire        lstb_s   = dat_s[19];
    wire        ustb_s   = dat_s[18];
    wire        lmask_s  = dat_s[17];
    wire        umask_s  = dat_s[16];
    wire [15:0] dq_s     = dat_s[15:0];

    ////////////////////////////////////////////////////////////////////////////////
    // asynchronous self-refresh wake

    wire in_sref = power_state_q[3];
    wire sr_wake = clock_gate_in & in_sref;

    // set without any clock edge, so a stopped clock cannot hide the exit
    always @(posedge clock or negedge rst_b or posedge sr_wake) begin
        if (!rst_b) begin
            wake_q <= 1'b0;
        end else if (sr_wake) begin
            wake_q <= 1'b1;
        end else begin
            wake_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode

    reg         gate_prev_q;
    reg  [13:0] mode_regs [0:3];
    wire [13:0] emr1 = mode_regs[`DDRCI_EMR1_INDEX];
    wire        any_open = |bank_open_q;

    wire selected  = ~code_s[3];
    wire cmd_live  = selected & cmd_buf_en_q;
    wire is_mode   = cmd_live & (code_s == `DDRCI_CMD_MODE);
    wire is_ref    = cmd_live & (code_s == `DDRCI_CMD_REFRESH);
    wire is_pre    = cmd_live & (code_s == `DDRCI_CMD_PRECHARGE);
    wire is_act    = cmd_live & (code_s == `DDRCI_CMD_ACTIVE);
    // reads and writes assume gate high
    wire is_wr     = cmd_live & gate_s & (code_s == `DDRCI_CMD_WRITE);
    wire is_rd     = cmd_live & gate_s & (code_s == `DDRCI_CMD_READ);
    wire pre_all   = addr_s[`DDRCI_PRE_ALL_BIT];
    wire any_cmd   = is_mode | is_ref | is_pre | is_act | is_wr | is_rd;

    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_bank
            wire hit = (bank_s == b[2:0]);
            ddrci_bank u_bank (
                .clock     (clock),
                .rst_b     (rst_b),
                .open_req  (is_act & hit),
                .close_req ((is_pre & (pre_all | hit)) |
                            ((is_rd | is_wr) & pre_all & hit)),
                .open_q    (bank_open_q[b])
            );
        end
    endgenerate

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid_q            <= 1'b0;
            cmd_code_q             <= `DDRCI_CMD_NOP;
            cmd_bank_q             <= 3'h0;
            row_addr_q             <= 14'h0000;
            col_addr_q             <= 14'h0000;
            auto_precharge_flag_q  <= 1'b0;
            precharge_all_select_q <= 1'b0;
            mode_set_cmd_q         <= 1'b0;
            extended_mode_set_q    <= 1'b0;
            mode_index_q           <= 3'h0;
            mode_opcode_q          <= 14'h0000;
        end else begin
            cmd_valid_q    <= any_cmd;
            mode_set_cmd_q <= is_mode & (bank_s[1:0] == 2'h0);
            extended_mode_set_q <= is_mode & (bank_s[1:0] != 2'h0);
            if (any_cmd) begin
                cmd_code_q <= code_s;
                cmd_bank_q <= bank_s;
            end
            if (is_act) begin
                row_addr_q <= addr_s;
            end
            if (is_rd | is_wr) begin
                col_addr_q            <= addr_s & ~(14'h0001 << `DDRCI_PRE_ALL_BIT);
                auto_precharge_flag_q <= pre_all;
            end
            if (is_pre) begin
                precharge_all_select_q <= pre_all;
            end
            if (is_mode) begin
                mode_index_q  <= bank_s;
                mode_opcode_q <= addr_s;
            end
        end
    end

    integer m;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (m = 0; m < 4; m = m + 1) begin
                mode_regs[m] <= `DDRCI_MODE_RESET;
            end
        end else if (is_mode) begin
            mode_regs[bank_s[1:0]] <= addr_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state

    reg [3:0] state_d;
    wire gate_fall = gate_prev_q & ~gate_s;

    always @* begin
        state_d = power_state_q;
        case (power_state_q)
            ST_RUN: begin
                if (gate_fall & is_ref & ~any_open) begin
                    state_d = ST_SELF_REF;
                end else if (gate_fall & any_open) begin
                    state_d = ST_ACT_PD;
                end else if (gate_fall) begin
                    state_d = ST_PRE_PD;
                end
            end
            ST_PRE_PD, ST_ACT_PD: begin
                if (gate_s) begin
                    state_d = ST_RUN;
                end
            end
            ST_SELF_REF: begin
                if (wake_s) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            power_state_q <= ST_RUN;
            gate_prev_q   <= 1'b0;
            clocks_on_q   <= 1'b0;
            drivers_en_q  <= 1'b0;
            cmd_buf_en_q  <= 1'b1;
            clk_buf_en_q  <= 1'b1;
        end else begin
            power_state_q <= state_d;
            gate_prev_q   <= gate_s;
            clocks_on_q   <= (state_d == ST_RUN);
            drivers_en_q  <= (state_d == ST_RUN);
            cmd_buf_en_q  <= (state_d == ST_RUN);
            clk_buf_en_q  <= (state_d != ST_SELF_REF);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // termination and mask mode

    wire rtt_on = emr1[`DDRCI_RTT0_BIT] | emr1[`DDRCI_RTT1_BIT];
    // mask pin as read strobe on x8 only
    wire mask_is_strobe = (ORG == 8) & emr1[`DDRCI_STROBE_BIT];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            term_dq_q        <= 1'b0;
            term_strobe_q    <= 1'b0;
            term_mask_q      <= 1'b0;
            read_strobe_oe_q <= 1'b0;
        end else begin
            term_dq_q        <= term_s & rtt_on & clk_buf_en_q;
            term_strobe_q    <= term_s & rtt_on & clk_buf_en_q;
            term_mask_q      <= term_s & rtt_on & clk_buf_en_q;
            read_strobe_oe_q <= mask_is_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write beats

    reg       lstb_prev_q;
    reg       ustb_prev_q;
    reg [3:0] beats_q;
    reg [3:0] beats_d;

    wire l_edge = lstb_s ^ lstb_prev_q;
    wire u_edge = ustb_s ^ ustb_prev_q;
    wire in_burst = (beats_q != `DDRCI_BEATS_RESET);
    wire l_store = l_edge & in_burst & (mask_is_strobe | ~lmask_s);
    // upper lane on its own strobe
    wire u_store = u_edge & in_burst & (ORG == 16) & ~umask_s;

    always @* begin
        beats_d = beats_q;
        if (is_wr) begin
            beats_d = BURST_LEN[3:0];
        end else if (l_edge & in_burst) begin
            beats_d = beats_q - 4'h1;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lstb_prev_q     <= 1'b0;
            ustb_prev_q     <= 1'b0;
            beats_q         <= `DDRCI_BEATS_RESET;
            wr_beat_q       <= 1'b0;
            wr_data_q       <= 16'h0000;
            wr_lane_store_q <= 2'h0;
        end else begin
            lstb_prev_q     <= lstb_s;
            ustb_prev_q     <= ustb_s;
            beats_q         <= beats_d;
            wr_beat_q       <= l_edge & in_burst;
            wr_lane_store_q <= {u_store, l_store};
            if (l_store) begin
                wr_data_q[7:0] <= dq_s[7:0];
            end
            if (u_store) begin
                wr_data_q[15:8] <= dq_s[15:8];
            end
        end
    end

endmodule // ddrci_top

// ==== sim/ddrci_ctrl_model.sv ====
// memory controller model driving the command, address and write data pins
module ddrci_ctrl_model (
    input  wire        clock,
    output reg         clock_gate_in,
    output reg         chip_select_b,
    output reg         row_strobe_b,
    output reg         col_strobe_b,
    output reg         write_enable_b,
    output reg         termination_enable,
    output reg  [2:0]  bank_select,
    output reg  [13:0] address_bus,
    output reg         lower_data_strobe,
    output reg         upper_data_strobe,
    output reg  [15:0] data_in,
    output reg         lower_byte_mask,
    output reg         upper_byte_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        clock_gate_in = 1'b1;
        {chip_select_b, row_strobe_b, col_strobe_b, write_enable_b} = 4'hf;
        termination_enable = 1'b0;
        bank_select = 3'h0;
        address_bus = 14'h0000;
        {lower_data_strobe, upper_data_strobe, lower_byte_mask, upper_byte_mask} = 4'h0;
        data_in = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // code and gate
    // gate changes only with a command slot, so it stays high through bursts
    task automatic send(input logic [3:0] code, input logic [2:0] ba, input logic [13:0] a,
                        input logic gate);
        @(posedge clock);
        {chip_select_b, row_strobe_b, col_strobe_b, write_enable_b} <= code;
        bank_select   <= ba;
        address_bus   <= a;
        clock_gate_in <= gate;
        @(posedge clock);
        {chip_select_b, row_strobe_b, col_strobe_b, write_enable_b} <= 4'hf;
        // released lines show garbage, not the last value
        bank_select   <= ~ba;
        address_bus   <= ~a;
    endtask
    task automatic set_term(input logic v);
        @(posedge clock);
        termination_enable <= v;
    endtask
    task automatic beat(input logic [15:0] d, input logic lm, input logic um);
        @(posedge clock);
        data_in           <= d;
        lower_byte_mask   <= lm;
        upper_byte_mask   <= um;
        lower_data_strobe <= ~lower_data_strobe;
        upper_data_strobe <= ~upper_data_strobe;
        @(posedge clock);
        @(posedge clock);
        data_in <= ~d;
    endtask
endmodule // ddrci_ctrl_model

// ==== sim/ddrci_top_bench.sv ====
// self-checking bench for the command input stage
`include "ddrci_consts.vh"
module ddrci_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          k;
    wire         gate, cs_b, ras_b, cas_b, we_b, term, lds, uds, lbm, ubm;
    wire [2:0]   ba;
    wire [13:0]  addr;
    wire [15:0]  din;
    always #50 clock = ~clock;
    ddrci_ctrl_model i_ctrl (
        .clock(clock), .clock_gate_in(gate), .chip_select_b(cs_b), .row_strobe_b(ras_b),
        .col_strobe_b(cas_b), .write_enable_b(we_b), .termination_enable(term),
        .bank_select(ba), .address_bus(addr), .lower_data_strobe(lds), .upper_data_strobe(uds),
        .data_in(din), .lower_byte_mask(lbm), .upper_byte_mask(ubm));
    ddrci_top #(.ORG(16), .BURST_LEN(4)) i_dut (
        .clock(clock), .rst_b(rst_b), .clock_gate_in(gate), .chip_select_b(cs_b),
        .row_strobe_b(ras_b), .col_strobe_b(cas_b), .write_enable_b(we_b),
        .termination_enable(term), .bank_select(ba), .address_bus(addr),
        .lower_data_strobe(lds), .upper_data_strobe(uds), .data_in(din),
        .lower_byte_mask(lbm), .upper_byte_mask(ubm), .clocks_on_q(), .drivers_en_q(),
        .cmd_buf_en_q(), .clk_buf_en_q(), .power_state_q(), .cmd_valid_q(), .cmd_code_q(),
        .cmd_bank_q(), .row_addr_q(), .col_addr_q(), .auto_precharge_flag_q(),
        .precharge_all_select_q(), .mode_set_cmd_q(), .extended_mode_set_q(),
        .mode_index_q(), .mode_opcode_q(), .bank_open_q(), .term_dq_q(), .term_strobe_q(),
        .term_mask_q(), .read_strobe_oe_q(), .wr_beat_q(), .wr_data_q(), .wr_lane_store_q());
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            $display("Error timeout expected finish seen hang");
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_cmd(input logic exp);
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 8 && !seen; n++) begin
            @(negedge clock);
            seen = (i_dut.cmd_valid_q === 1'b1);
        end
        check("command seen", 16'(exp), 16'(seen));
    endtask
    task automatic wait_state(input logic [3:0] exp);
        int n;
        for (n = 0; n < 8; n++) begin
            @(negedge clock);
            if (i_dut.power_state_q === exp) break;
        end
        check("power state", 16'(exp), 16'(i_dut.power_state_q));
    endtask
    task automatic do_beat(input logic [15:0] d, input logic lm, input logic um,
                           input logic exp);
        int n;
        logic seen;
        seen = 1'b0;
        i_ctrl.beat(d, lm, um);
        for (n = 0; n < 6 && !seen; n++) begin
            @(negedge clock);
            seen = (i_dut.wr_beat_q === 1'b1);
        end
        check("write beat", 16'(exp), 16'(seen));
        if (seen) begin
            check("lanes stored", 16'({~um, ~lm}), 16'(i_dut.wr_lane_store_q));
            if (!um) check("upper lane", 16'(d[15:8]), 16'(i_dut.wr_data_q[15:8]));
            if (!lm) check("lower lane", 16'(d[7:0]), 16'(i_dut.wr_data_q[7:0]));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(negedge clock);
        check("clocks on", 16'h1, 16'(i_dut.clocks_on_q));
        check("drivers on", 16'h1, 16'(i_dut.drivers_en_q));
        i_ctrl.send(`DDRCI_CMD_MODE, 3'h0, 14'h0123, 1'b1);
        wait_cmd(1'b1);
        check("base mode", 16'h1, 16'(i_dut.mode_set_cmd_q));
        check("mode opcode", 16'h0123, 16'(i_dut.mode_opcode_q));
        i_ctrl.send(`DDRCI_CMD_MODE, 3'h1, 14'h0844, 1'b1);
        wait_cmd(1'b1);
        check("ext mode", 16'h1, 16'(i_dut.extended_mode_set_q));
        check("mode index", 16'h1, 16'(i_dut.mode_index_q));
        check("x16 mask stays", 16'h0, 16'(i_dut.read_strobe_oe_q));
        i_ctrl.set_term(1'b1);
        repeat (5) @(negedge clock);
        check("term dq", 16'h1, 16'(i_dut.term_dq_q));
        check("term strobe", 16'h1, 16'(i_dut.term_strobe_q));
        check("term mask", 16'h1, 16'(i_dut.term_mask_q));
        i_ctrl.send(`DDRCI_CMD_MODE, 3'h1, 14'h0000, 1'b1);
        wait_cmd(1'b1);
        repeat (3) @(negedge clock);
        check("term off", 16'h0, 16'(i_dut.term_dq_q));
        $display("test mode and termination done");
        i_ctrl.send(4'hb, 3'h3, 14'h0555, 1'b1);
        wait_cmd(1'b0);
        i_ctrl.send(`DDRCI_CMD_ACTIVE, 3'h3, 14'h1abc, 1'b1);
        wait_cmd(1'b1);
        check("cmd code", 16'(`DDRCI_CMD_ACTIVE), 16'(i_dut.cmd_code_q));
        check("row", 16'h1abc, 16'(i_dut.row_addr_q));
        check("cmd bank", 16'h3, 16'(i_dut.cmd_bank_q));
        i_ctrl.send(`DDRCI_CMD_ACTIVE, 3'h5, 14'h0042, 1'b1);
        wait_cmd(1'b1);
        @(negedge clock);
        check("open banks", 16'h0028, 16'(i_dut.bank_open_q));
        i_ctrl.send(`DDRCI_CMD_PRECHARGE, 3'h3, 14'h0000, 1'b1);
        wait_cmd(1'b1);
        @(negedge clock);
        check("one closed", 16'h0020, 16'(i_dut.bank_open_q));
        $display("test bank commands done");
        i_ctrl.send(`DDRCI_CMD_WRITE, 3'h5, 14'h0010, 1'b1);
        wait_cmd(1'b1);
        check("write column", 16'h0010, 16'(i_dut.col_addr_q));
        for (k = 0; k < 4; k++) begin
            do_beat(16'h1111 * 16'(k + 1), k == 1, k == 2, 1'b1);
        end
        do_beat(16'h5a5a, 1'b0, 1'b0, 1'b0);
        i_ctrl.send(`DDRCI_CMD_READ, 3'h5, 14'h0410, 1'b1);
        wait_cmd(1'b1);
        check("auto precharge", 16'h1, 16'(i_dut.auto_precharge_flag_q));
        check("read column", 16'h0010, 16'(i_dut.col_addr_q));
        @(negedge clock);
        check("auto closed", 16'h0000, 16'(i_dut.bank_open_q));
        $display("test write and read done");
        i_ctrl.send(`DDRCI_CMD_ACTIVE, 3'h2, 14'h0007, 1'b1);
        wait_cmd(1'b1);
        i_ctrl.send(4'hf, 3'h0, 14'h0000, 1'b0);
        wait_state(`DDRCI_ST_ACT_PD);
        check("clocks off", 16'h0, 16'(i_dut.clocks_on_q));
        check("cmd buffer off", 16'h0, 16'(i_dut.cmd_buf_en_q));
        check("clk buffer on", 16'h1, 16'(i_dut.clk_buf_en_q));
        i_ctrl.send(`DDRCI_CMD_PRECHARGE, 3'h0, 14'h0400, 1'b0);
        wait_cmd(1'b0);
        i_ctrl.send(4'hf, 3'h0, 14'h0000, 1'b1);
        wait_state(`DDRCI_ST_RUN);
        i_ctrl.send(`DDRCI_CMD_PRECHARGE, 3'h0, 14'h0400, 1'b1);
        wait_cmd(1'b1);
        check("precharge all", 16'h1, 16'(i_dut.precharge_all_select_q));
        @(negedge clock);
        check("all closed", 16'h0000, 16'(i_dut.bank_open_q));
        i_ctrl.send(4'hf, 3'h0, 14'h0000, 1'b0);
        wait_state(`DDRCI_ST_PRE_PD);
        i_ctrl.send(4'hf, 3'h0, 14'h0000, 1'b1);
        wait_state(`DDRCI_ST_RUN);
        $display("test power-down done");
        i_ctrl.send(`DDRCI_CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
        wait_state(`DDRCI_ST_SELF_REF);
        check("clk buffer off", 16'h0, 16'(i_dut.clk_buf_en_q));
        i_ctrl.send(4'hf, 3'h0, 14'h0000, 1'b1);
        wait_state(`DDRCI_ST_RUN);
        $display("test self refresh done");
        final_report();
    end
endmodule // ddrci_top_bench

// ==== sim/ddrci_top_monitor.sv ====
// concurrent checks on the ports of the command input stage
`include "ddrci_consts.vh"
module ddrci_top_monitor (
    input wire        clock,
    input wire        rst_b,
    input wire        clock_gate_in,
    input wire        chip_select_b,
    input wire        termination_enable,
    input wire        lower_byte_mask,
    input wire        clocks_on_q,
    input wire        drivers_en_q,
    input wire        cmd_buf_en_q,
    input wire        clk_buf_en_q,
    input wire [3:0]  power_state_q,
    input wire        cmd_valid_q,
    input wire [3:0]  cmd_code_q,
    input wire        precharge_all_select_q,
    input wire        mode_set_cmd_q,
    input wire        extended_mode_set_q,
    input wire [2:0]  mode_index_q,
    input wire [7:0]  bank_open_q,
    input wire        term_dq_q,
    input wire        wr_beat_q,
    input wire [1:0]  wr_lane_store_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    cs_masked_a: assert property (chip_select_b |-> ##3 !cmd_valid_q)
        else $error("command decoded with chip select high");
    base_mode_a: assert property (mode_set_cmd_q |-> mode_index_q[1:0] == 2'h0)
        else $error("base mode pulse with nonzero bank select");
    ext_mode_a: assert property (extended_mode_set_q |-> mode_index_q[1:0] != 2'h0)
        else $error("extended mode pulse with zero bank select");
    asleep_off_a: assert property (power_state_q != `DDRCI_ST_RUN
        |-> !clocks_on_q && !drivers_en_q && !cmd_buf_en_q)
        else $error("clocks or buffers on while powered down");
    sref_clkbuf_a: assert property ((power_state_q == `DDRCI_ST_SELF_REF) == !clk_buf_en_q)
        else $error("clock buffer enable disagrees with self refresh");
    asleep_nocmd_a: assert property ($past(power_state_q) != `DDRCI_ST_RUN
        && power_state_q != `DDRCI_ST_RUN |-> !cmd_valid_q)
        else $error("command decoded while asleep");
    gate_entry_a: assert property ($fell(clock_gate_in) && power_state_q == `DDRCI_ST_RUN
        |-> ##3 power_state_q != `DDRCI_ST_RUN)
        else $error("gate low did not enter a low power state");
    pd_exit_a: assert property ($rose(clock_gate_in) && (power_state_q == `DDRCI_ST_PRE_PD
        || power_state_q == `DDRCI_ST_ACT_PD) |-> ##[1:4] power_state_q == `DDRCI_ST_RUN)
        else $error("power-down exit too slow");
    pre_all_a: assert property (cmd_valid_q && cmd_code_q == `DDRCI_CMD_PRECHARGE
        && precharge_all_select_q |-> ##[0:1] bank_open_q == 8'h00)
        else $error("precharge all left a bank open");
    term_pin_a: assert property (term_dq_q |-> $past(termination_enable, 3))
        else $error("termination without enable pin");
    mask_drop_a: assert property (wr_beat_q && $past(lower_byte_mask, 3)
        |-> !wr_lane_store_q[0])
        else $error("masked lower lane stored");
endmodule // ddrci_top_monitor

bind ddrci_top ddrci_top_monitor i_mon (
    .clock(clock), .rst_b(rst_b), .clock_gate_in(clock_gate_in),
    .chip_select_b(chip_select_b), .termination_enable(termination_enable),
    .lower_byte_mask(lower_byte_mask), .clocks_on_q(clocks_on_q), .drivers_en_q(drivers_en_q),
    .cmd_buf_en_q(cmd_buf_en_q), .clk_buf_en_q(clk_buf_en_q), .power_state_q(power_state_q),
    .cmd_valid_q(cmd_valid_q), .cmd_code_q(cmd_code_q),
    .precharge_all_select_q(precharge_all_select_q), .mode_set_cmd_q(mode_set_cmd_q),
    .extended_mode_set_q(extended_mode_set_q), .mode_index_q(mode_index_q),
    .bank_open_q(bank_open_q), .term_dq_q(term_dq_q), .wr_beat_q(wr_beat_q),
    .wr_lane_store_q(wr_lane_store_q)
);
